/* File: sec_lock_pkg.sv */
/*
 * constants, types and command decode for the drive access-lock gate.
 * assumes one 100 MHz clock and synchronous command and register strobes.
 */
package sec_lock_pkg;

   // ****************************************************************
   // widths and counts
   // ****************************************************************
   localparam int          PW_W            = 256;     // 32-byte password
   localparam int          REV_W           = 16;
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 32;
   localparam int          CNT_W           = 3;
   localparam int          STAT_W          = 4;
   localparam logic [2:0]  MISMATCH_LIMIT  = 3'h5;

   // ****************************************************************
   // security opcodes
   // ****************************************************************
   localparam logic [7:0]  OP_SET_PW       = 8'hF1;
   localparam logic [7:0]  OP_UNLOCK       = 8'hF2;
   localparam logic [7:0]  OP_ERASE_PREP   = 8'hF3;
   localparam logic [7:0]  OP_ERASE_UNIT   = 8'hF4;
   localparam logic [7:0]  OP_FREEZE       = 8'hF5;
   localparam logic [7:0]  OP_DISABLE_PW   = 8'hF6;

   // ****************************************************************
   // feature word fields and reset values
   // ****************************************************************
   localparam int          FEAT_MASTER_BIT = 0;       // 1 = master password
   localparam int          FEAT_MAXLVL_BIT = 8;       // 1 = maximum level
   localparam logic [15:0] REV_DEFAULT     = 16'hFFFE;
   localparam logic [15:0] REV_MIN         = 16'h0001;
   localparam logic [15:0] REV_MAX         = 16'hFFFE;
   localparam logic [PW_W-1:0] MASTER_PW_DEFAULT = '0; // arbitrary value

   // ****************************************************************
   // identify word 128 bit positions
   // ****************************************************************
   localparam int          W128_SUPP       = 0;
   localparam int          W128_EN         = 1;
   localparam int          W128_LOCKED     = 2;
   localparam int          W128_FROZEN     = 3;
   localparam int          W128_EXHAUST    = 4;
   localparam int          W128_LEVEL      = 8;

   // ****************************************************************
   // register map and status bits
   // ****************************************************************
   localparam logic [7:0]  REG_STATUS      = 8'h00;
   localparam logic [7:0]  REG_MASK        = 8'h04;
   localparam logic [7:0]  REG_MODE        = 8'h08;
   localparam logic [7:0]  REG_ID92        = 8'h0C;
   localparam logic [7:0]  REG_ID128       = 8'h10;
   localparam int          ST_ABORT        = 0;
   localparam int          ST_UNLOCK       = 1;
   localparam int          ST_EXHAUST      = 2;
   localparam int          ST_ERASE        = 3;

   typedef enum logic [2:0] {
      MODE_UNLOCKED = 3'b001,
      MODE_LOCKED   = 3'b010,
      MODE_FROZEN   = 3'b100
   } mode_e;

   // commands that touch media or configuration: aborted while locked
   function automatic logic is_media_cmd(input logic [7:0] op, input logic [7:0] feat);
      case (op)
         8'h20, 8'h24, 8'h25, 8'h29, 8'h2A, 8'h2B, 8'h2F,
         8'h22, 8'h32, 8'h30, 8'h34, 8'h35, 8'h39, 8'h3A,
         8'h3B, 8'h3F, 8'h40, 8'h42, 8'hC4, 8'hC5, 8'hC8,
         8'hCA, 8'hE7, 8'hEA, 8'h50, 8'h51, 8'h92, 8'h37,
         8'hF9:   is_media_cmd = 1'b1;
         8'hB1:   is_media_cmd = (feat == 8'hC0) || (feat == 8'hC3);
         default: is_media_cmd = 1'b0;
      endcase
   endfunction

endpackage

/* File: sec_pw_compare.sv */
/*
 * password comparator: checks a presented password against the stored
 * user or master password. assumes all inputs are stable in one cycle.
 */
`timescale 1ns/1ps
module sec_pw_compare
   import sec_lock_pkg::*;
(
   input  wire logic [PW_W-1:0] i_pw,
   input  wire logic [PW_W-1:0] i_user_pw,
   input  wire logic [PW_W-1:0] i_master_pw,
   input  wire logic            i_sel_master,
   output logic                 o_match
);

   logic [PW_W-1:0] ref_pw;

   // compare every bit, no early exit
   always_comb begin
      ref_pw  = i_sel_master ? i_master_pw : i_user_pw;
      o_match = ~|(ref_pw ^ i_pw);
   end

endmodule // sec_pw_compare

/* File: sec_lock_gate.sv */
/*
 * drive access-lock gate: decodes host commands, keeps passwords, lock
 * mode, attempt counter and identify words, and lets commands execute or
 * aborts them. assumes one command strobe per cycle from the command
 * front end, synchronous to i_sys_clk; i_rstn is power-on reset and
 * i_hard_rst a one-cycle synchronous hard reset.
 */
`timescale 1ns/1ps
// Overview of operation
// - high level: correct master password unlocks like the user password
// - maximum level: master unlocks only via erase unit, which erases data
// - master password never enables lock; it only unlocks
// - identify word 92 reports master revision code, valid 0001h to FFFEh
// - setting user password enables lock; locked after next hard reset
// - replacing default master password leaves lock function off
// - master revision code defaults to FFFEh
// - with lock enabled after reset, media commands rejected until unlock
// - one mismatch counter for master and user failures
// - at count 5 set exhausted bit 4 of word 128, abort unlock/erase
// - power-on or hard reset clears counter and exhausted flag
// - media and configuration commands aborted locked, run unlocked/frozen
// - identify, power, idle, diagnostic and similar run in every mode
// - power-on: always unlocked; clears lock enable and user password
// - freeze lock enters frozen until power-off, blocks password changes
// - security opcodes F1 to F6 decoded
// - frozen aborts erase, set password, unlock; freeze aborted locked
module sec_lock_gate
   import sec_lock_pkg::*;
(
   input  wire logic              i_sys_clk,
   input  wire logic              i_rstn,
   input  wire logic              i_hard_rst,
   input  wire logic              i_cmd_valid,
   input  wire logic [7:0]        i_cmd_opcode,
   input  wire logic [15:0]       i_cmd_feature,
   input  wire logic [PW_W-1:0]   i_cmd_pw,
   input  wire logic [REV_W-1:0]  i_cmd_rev,
   output logic                   o_cmd_exec,
   output logic                   o_cmd_abort,
   output logic                   o_erase_start,
   output logic [15:0]            o_word92,
   output logic [15:0]            o_word128,
   input  wire logic [ADDR_W-1:0] i_reg_addr,
   input  wire logic [DATA_W-1:0] i_reg_wdata,
   input  wire logic              i_reg_wr,
   input  wire logic              i_reg_rd,
   output logic [DATA_W-1:0]      o_reg_rdata,
   output logic                   o_irq
);

   // ****************************************************************
   // state
   // ****************************************************************
   mode_e               mode_q;
   mode_e               mode_d;
   logic                lock_en_q;
   logic                level_max_q;
   logic                prepared_q;
   logic [CNT_W-1:0]    cnt_q;
   logic                exhausted_q;
   logic [PW_W-1:0]     user_pw_q;
   logic [PW_W-1:0]     master_pw_q;
   logic [REV_W-1:0]    rev_q;
   logic [STAT_W-1:0]   stat_q;
   logic [STAT_W-1:0]   mask_q;
   logic                pw_match;
   logic                sel_master;
   logic                cmd;
   logic                exec_d;
   logic                abort_d;
   logic                set_user;
   logic                set_master;
   logic                unlock_ok;
   logic                erase_ok;
   logic                disable_ok;
   logic                freeze_ok;
   logic                prep_ok;
   logic                mismatch;
   logic                media;

   assign sel_master = i_cmd_feature[FEAT_MASTER_BIT];
   assign cmd        = i_cmd_valid && !i_hard_rst;
   assign media      = is_media_cmd(i_cmd_opcode, i_cmd_feature[7:0]);

   sec_pw_compare u_cmp (
      .i_pw         (i_cmd_pw),
      .i_user_pw    (user_pw_q),
      .i_master_pw  (master_pw_q),
      .i_sel_master (sel_master),
      .o_match      (pw_match)
   );

   // ****************************************************************
   // command decode and mode checks
   // ****************************************************************
   always_comb begin
      exec_d     = 1'b0;
      abort_d    = 1'b0;
      set_user   = 1'b0;
      set_master = 1'b0;
      unlock_ok  = 1'b0;
      erase_ok   = 1'b0;
      disable_ok = 1'b0;
      freeze_ok  = 1'b0;
      prep_ok    = 1'b0;
      mismatch   = 1'b0;
      if (cmd) begin
         case (i_cmd_opcode)
            OP_SET_PW: begin
               if (mode_q != MODE_UNLOCKED) begin
                  abort_d = 1'b1;
               end else if (sel_master) begin
                  set_master = 1'b1;
               end else begin
                  set_user = 1'b1;
               end
            end
            OP_UNLOCK: begin
               if (mode_q == MODE_FROZEN || exhausted_q) begin
                  abort_d = 1'b1;
               end else if (!lock_en_q) begin
                  unlock_ok = 1'b1;
               end else if (!pw_match) begin
                  mismatch = 1'b1;
                  abort_d  = 1'b1;
               end else if (sel_master && level_max_q) begin
                  abort_d = 1'b1;
               end else begin
                  unlock_ok = 1'b1;
               end
            end
            OP_ERASE_PREP: begin
               if (mode_q == MODE_FROZEN) begin
                  abort_d = 1'b1;
               end else begin
                  prep_ok = 1'b1;
               end
            end
            OP_ERASE_UNIT: begin
               if (mode_q == MODE_FROZEN || exhausted_q || !prepared_q) begin
                  abort_d = 1'b1;
               end else if (!pw_match) begin
                  mismatch = 1'b1;
                  abort_d  = 1'b1;
               end else begin
                  erase_ok = 1'b1;
               end
            end
            OP_FREEZE: begin
               if (mode_q == MODE_LOCKED) begin
                  abort_d = 1'b1;
               end else begin
                  freeze_ok = 1'b1;
               end
            end
            OP_DISABLE_PW: begin
               if (mode_q != MODE_UNLOCKED || !pw_match) begin
                  abort_d = 1'b1;
               end else begin
                  disable_ok = 1'b1;
               end
            end
            default: begin
               abort_d = media && (mode_q == MODE_LOCKED);
            end
         endcase
         exec_d = !abort_d;
      end
   end

   // ****************************************************************
   // command answer: one cycle after the strobe
   // ****************************************************************
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_cmd_exec    <= 1'b0;
         o_cmd_abort   <= 1'b0;
         o_erase_start <= 1'b0;
      end else begin
         o_cmd_exec    <= exec_d;
         o_cmd_abort   <= abort_d;
         o_erase_start <= erase_ok;
      end
   end

   // lock mode machine
   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         MODE_UNLOCKED: begin
            if (i_hard_rst && lock_en_q) begin
               mode_d = MODE_LOCKED;
            end else if (freeze_ok) begin
               mode_d = MODE_FROZEN;
            end
         end
         MODE_LOCKED: begin
            if (unlock_ok || erase_ok) begin
               mode_d = MODE_UNLOCKED;
            end
         end
         MODE_FROZEN:   mode_d = MODE_FROZEN;
         default:       mode_d = MODE_UNLOCKED;
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         mode_q <= MODE_UNLOCKED;
      end else begin
         mode_q <= mode_d;
      end
   end

   // lock function enable and level
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         lock_en_q   <= 1'b0;
         level_max_q <= 1'b0;
      end else if (set_user) begin
         lock_en_q   <= 1'b1;
         level_max_q <= i_cmd_feature[FEAT_MAXLVL_BIT];
      end else if (disable_ok || erase_ok) begin
         lock_en_q   <= 1'b0;
      end
   end

   // password store and master revision code
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         user_pw_q   <= '0;
         master_pw_q <= MASTER_PW_DEFAULT;
         rev_q       <= REV_DEFAULT;
      end else if (set_user) begin
         user_pw_q <= i_cmd_pw;
      end else if (set_master) begin
         master_pw_q <= i_cmd_pw;
         if (i_cmd_rev >= REV_MIN && i_cmd_rev <= REV_MAX) begin
            rev_q <= i_cmd_rev;
         end
      end
   end

   // erase prepare must directly precede erase unit
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         prepared_q <= 1'b0;
      end else if (i_hard_rst) begin
         prepared_q <= 1'b0;
      end else if (cmd) begin
         prepared_q <= prep_ok;
      end
   end

   // mismatch counter, saturating, and exhausted flag
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt_q       <= '0;
         exhausted_q <= 1'b0;
      end else if (i_hard_rst) begin
         cnt_q       <= '0;
         exhausted_q <= 1'b0;
      end else if (mismatch && cnt_q != MISMATCH_LIMIT) begin
         cnt_q <= cnt_q + 3'h1;
         if (cnt_q + 3'h1 == MISMATCH_LIMIT) begin
            exhausted_q <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // identify words
   // ****************************************************************
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_word92  <= REV_DEFAULT;
         o_word128 <= '0;
      end else begin
         o_word92                <= rev_q;
         o_word128               <= '0;
         o_word128[W128_SUPP]    <= 1'b1;
         o_word128[W128_EN]      <= lock_en_q;
         o_word128[W128_LOCKED]  <= mode_q == MODE_LOCKED;
         o_word128[W128_FROZEN]  <= mode_q == MODE_FROZEN;
         o_word128[W128_EXHAUST] <= exhausted_q;
         o_word128[W128_LEVEL]   <= level_max_q;
      end
   end

   // ****************************************************************
   // register port and interrupt
   // ****************************************************************
   logic [STAT_W-1:0] stat_set;
   logic              stat_rd;

   assign stat_set = {erase_ok,
                      mismatch && (cnt_q + 3'h1 == MISMATCH_LIMIT),
                      unlock_ok, abort_d};
   assign stat_rd  = i_reg_rd && i_reg_addr == REG_STATUS;

   // sticky status, read clears, new events win
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         stat_q <= '0;
      end else begin
         stat_q <= (stat_q & ~{STAT_W{stat_rd}}) | stat_set;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         mask_q <= '0;
      end else if (i_reg_wr && i_reg_addr == REG_MASK) begin
         mask_q <= i_reg_wdata[STAT_W-1:0];
      end
   end

   // read data stands one cycle after the strobe; unmapped reads zero
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_reg_rdata <= '0;
      end else begin
         o_reg_rdata <= '0;
         if (i_reg_rd) begin
            case (i_reg_addr)
               REG_STATUS: o_reg_rdata <= {28'h0000000, stat_q};
               REG_MASK:   o_reg_rdata <= {28'h0000000, mask_q};
               REG_MODE:   o_reg_rdata <= {24'h000000, cnt_q, level_max_q, lock_en_q, mode_q};
               REG_ID92:   o_reg_rdata <= {16'h0000, o_word92};
               REG_ID128:  o_reg_rdata <= {16'h0000, o_word128};
               default:    o_reg_rdata <= '0;
            endcase
         end
      end
   end

   assign o_irq = |(stat_q & mask_q);

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);

   locked_media_a: assert property (cmd && mode_q == MODE_LOCKED && media &&
         i_cmd_opcode[7:3] != 5'h1E |=> o_cmd_abort && !o_cmd_exec)
      else $error("media command ran while locked");
   plain_exec_a: assert property (cmd && !media && i_cmd_opcode[7:3] != 5'h1E
         |=> o_cmd_exec)
      else $error("mode-free command was aborted");
   exhaust_abort_a: assert property (cmd && exhausted_q &&
         (i_cmd_opcode == OP_UNLOCK || i_cmd_opcode == OP_ERASE_UNIT) |=> o_cmd_abort)
      else $error("unlock or erase ran after attempts exhausted");
   exhaust_sticky_a: assert property (exhausted_q && !i_hard_rst |=>
         exhausted_q && cnt_q == MISMATCH_LIMIT)
      else $error("exhausted flag or count changed");
   hard_clear_a: assert property (i_hard_rst |=> cnt_q == '0 && !exhausted_q
         ##1 !o_word128[W128_EXHAUST])
      else $error("hard reset left count or flag set");
   frozen_stay_a: assert property (mode_q == MODE_FROZEN |=> mode_q == MODE_FROZEN)
      else $error("left frozen mode");
   master_nolock_a: assert property (cmd && i_cmd_opcode == OP_SET_PW && sel_master
         |=> lock_en_q == $past(lock_en_q) && mode_q == $past(mode_q))
      else $error("master password changed lock state");
   user_lock_a: assert property (set_user ##1
         (!disable_ok && !erase_ok && !freeze_ok)[*2] ##0 i_hard_rst |=> mode_q == MODE_LOCKED)
      else $error("user password did not lock after hard reset");
   rev_range_a: assert property (o_word92 >= REV_MIN && o_word92 <= REV_MAX)
      else $error("revision code out of range");
   max_master_a: assert property (cmd && i_cmd_opcode == OP_UNLOCK && sel_master
         && lock_en_q && level_max_q && mode_q == MODE_LOCKED |=> mode_q == MODE_LOCKED)
      else $error("master unlocked at maximum level");

   unlock_c: cover property (mode_q == MODE_LOCKED ##1 mode_q == MODE_UNLOCKED);
   erase_c:  cover property (o_erase_start);
   unlock_attempts_exhausted_c: cover property (!exhausted_q ##1 exhausted_q);
   freeze_c: cover property (mode_q == MODE_FROZEN);

endmodule // sec_lock_gate

/* File: host_cmd_model.sv */
/* host controller model: issues one drive command per call.
   assumes registered one-cycle exec/abort answers from the gate. */
`timescale 1ns/1ps
module host_cmd_model
   import sec_lock_pkg::*;
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_exec,
   input  wire logic        i_abort,
   input  wire logic        i_erase,
   output logic             o_valid,
   output logic [7:0]       o_op,
   output logic [15:0]      o_feat,
   output logic [PW_W-1:0]  o_pw,
   output logic [REV_W-1:0] o_rev
);
   // ********************
   // command issue
   // ********************
   // idle command port at time zero
   initial begin
      {o_valid, o_op, o_feat, o_pw, o_rev} = '0;
   end
   // one-cycle strobe, released lines toggle so stale values never pass
   task automatic issue(input logic [7:0] op, input logic [15:0] f,
                        input logic [PW_W-1:0] pw, input logic [15:0] rv,
                        output logic ex, output logic ab, output logic es);
      @(posedge i_sys_clk);
      {o_valid, o_op, o_feat, o_pw, o_rev} <= {1'b1, op, f, pw, rv};
      @(posedge i_sys_clk);
      {o_valid, o_op, o_feat, o_pw, o_rev} <= {1'b0, ~op, ~f, ~pw, ~rv};
      #1;
      {ex, ab, es} = {i_exec, i_abort, i_erase};
   endtask
endmodule // host_cmd_model

/* File: tb_top.sv */
/* self-checking bench for the access-lock gate.
   assumes the host model owns the command port; bench owns resets and registers. */
`timescale 1ns/1ps
module tb_top
   import sec_lock_pkg::*;
;
   logic              clk = 1'b0, rstn = 1'b0, hrst = 1'b0, rwr = 1'b0, rrd = 1'b0;
   logic [7:0]        raddr = 8'h00, cop;
   logic [31:0]       rwdata = 32'h0, rdata, d;
   logic              cv, ex, ab, es, irq, last_es;
   logic [15:0]       cf, cr, w92, w128;
   logic [PW_W-1:0]   cpw;
   int                err_count = 0, comparisons = 0;
   localparam logic [PW_W-1:0] MPW = {8{32'hA5C3_0F1E}}, UPW = {8{32'h1234_5678}};
   localparam logic [PW_W-1:0] BAD = {8{32'hFFFF_FFFF}};
   // 100 MHz clock
   always #5 clk = ~clk;
   sec_lock_gate i_sec_lock_gate (.i_sys_clk(clk), .i_rstn(rstn), .i_hard_rst(hrst),
      .i_cmd_valid(cv), .i_cmd_opcode(cop), .i_cmd_feature(cf), .i_cmd_pw(cpw),
      .i_cmd_rev(cr), .o_cmd_exec(ex), .o_cmd_abort(ab), .o_erase_start(es),
      .o_word92(w92), .o_word128(w128), .i_reg_addr(raddr), .i_reg_wdata(rwdata),
      .i_reg_wr(rwr), .i_reg_rd(rrd), .o_reg_rdata(rdata), .o_irq(irq));
   host_cmd_model i_host_cmd_model (.i_sys_clk(clk), .i_exec(ex), .i_abort(ab),
      .i_erase(es), .o_valid(cv), .o_op(cop), .o_feat(cf), .o_pw(cpw), .o_rev(cr));
   // ********************
   // shared tasks
   // ********************
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // issue one command and expect exec (e=1) or abort (e=0)
   task automatic cmd(input logic [7:0] op, input logic [15:0] f,
                      input logic [PW_W-1:0] pw, input logic [15:0] rv, input logic e);
      logic x, a;
      i_host_cmd_model.issue(op, f, pw, rv, x, a, last_es);
      chk({30'h0, x, a}, {30'h0, e, ~e});
   endtask
   task automatic w128chk(input logic [15:0] e);
      @(posedge clk);
      #1;
      chk(32'(w128), 32'(e));
   endtask
   task automatic hard();
      @(posedge clk);
      hrst <= 1'b1;
      @(posedge clk);
      hrst <= 1'b0;
      @(posedge clk);
   endtask
   task automatic regwr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      {rwr, raddr, rwdata} <= {1'b1, a, v};
      @(posedge clk);
      {rwr, rwdata} <= {1'b0, ~v};
      #1;
   endtask
   task automatic regrd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      {rrd, raddr} <= {1'b1, a};
      @(posedge clk);
      rrd <= 1'b0;
      #1;
      v = rdata;
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ********************
   // scenarios
   // ********************
   task automatic t_master();
      w128chk(16'h0001);
      chk(32'(w92), 32'h0000_FFFE);
      cmd(OP_SET_PW, 16'h0001, MPW, 16'h1234, 1'b1);
      w128chk(16'h0001);
      chk(32'(w92), 32'h0000_1234);
      i_host_cmd_model.issue(OP_SET_PW, 16'h0001, MPW, 16'h0000, d[0], d[1], d[2]);
      w128chk(16'h0001);
      chk(32'(w92), 32'h0000_1234);
      $display("test master done");
   endtask
   task automatic t_user_lock();
      cmd(OP_SET_PW, 16'h0000, UPW, 16'h0000, 1'b1);
      w128chk(16'h0003);
      hard();
      w128chk(16'h0007);
      cmd(8'h20, 16'h0000, BAD, 16'h0000, 1'b0);
      cmd(8'hEC, 16'h0000, BAD, 16'h0000, 1'b1);
      cmd(OP_FREEZE, 16'h0000, BAD, 16'h0000, 1'b0);
      cmd(OP_UNLOCK, 16'h0001, MPW, 16'h0000, 1'b1);
      chk(32'(last_es), 32'h0);
      w128chk(16'h0003);
      cmd(8'h20, 16'h0000, BAD, 16'h0000, 1'b1);
      $display("test user lock done");
   endtask
   task automatic t_attempts();
      hard();
      for (int i = 0; i < 5; i++) begin
         cmd(OP_UNLOCK, {15'h0000, i[0]}, BAD, 16'h0000, 1'b0);
      end
      w128chk(16'h0017);
      cmd(OP_UNLOCK, 16'h0000, UPW, 16'h0000, 1'b0);
      cmd(OP_UNLOCK, 16'h0000, BAD, 16'h0000, 1'b0);
      w128chk(16'h0017);
      chk(32'(irq), 32'h0);
      regwr(REG_MASK, 32'h0000_0004);
      chk(32'(irq), 32'h1);
      regrd(REG_MASK, d);
      chk(d, 32'h0000_0004);
      regrd(REG_STATUS, d);
      chk(32'(d[ST_EXHAUST]), 32'h1);
      regrd(8'h20, d);
      chk(d, 32'h0);
      chk(32'(irq), 32'h0);
      hard();
      w128chk(16'h0007);
      cmd(OP_UNLOCK, 16'h0000, UPW, 16'h0000, 1'b1);
      $display("test attempts done");
   endtask
   task automatic t_frozen();
      logic [7:0] ops [5] = '{OP_SET_PW, OP_UNLOCK, OP_ERASE_PREP, OP_ERASE_UNIT, OP_DISABLE_PW};
      cmd(OP_FREEZE, 16'h0000, BAD, 16'h0000, 1'b1);
      w128chk(16'h000B);
      foreach (ops[i]) cmd(ops[i], 16'h0000, UPW, 16'h0000, 1'b0);
      cmd(8'h20, 16'h0000, BAD, 16'h0000, 1'b1);
      $display("test frozen done");
   endtask
   task automatic t_max();
      @(posedge clk);
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      cmd(OP_SET_PW, 16'h0001, MPW, 16'h0002, 1'b1);
      cmd(OP_SET_PW, 16'h0100, UPW, 16'h0000, 1'b1);
      hard();
      w128chk(16'h0107);
      cmd(OP_UNLOCK, 16'h0001, MPW, 16'h0000, 1'b0);
      cmd(OP_ERASE_PREP, 16'h0000, BAD, 16'h0000, 1'b1);
      cmd(OP_ERASE_UNIT, 16'h0001, MPW, 16'h0000, 1'b1);
      chk(32'(last_es), 32'h1);
      w128chk(16'h0101);
      $display("test max level done");
   endtask
   // watchdog cuts a hang short
   initial begin
      repeat (50000) @(posedge clk);
      err_count++;
      complete_run();
   end
   // main sequence
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      t_master();
      t_user_lock();
      t_attempts();
      t_frozen();
      t_max();
      complete_run();
   end
endmodule // tb_top
